// ---- cgi_codec_gpio.sv ----
// Purpose: codec gpio, virtual gpio, status and interrupt logic with link
// Assumes: pins and analogue flags asynchronous; two-flop synchronised
// Notes:   gpio n sits at vector index n; index 0 unused
//
// Local design decision: the APB interface to the registers.
module cgi_codec_gpio #(
  parameter int DELAY_BASE = cgi_pkg::DELAY_BASE_DEF,
  parameter int LINK_HALF  = cgi_pkg::LINK_HALF_DEF
) (
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  cgi_link_if.dev         link_if,
  input  wire logic [8:1] gpio_pin_i,
  output logic      [8:1] gpio_pin_o,
  output logic      [8:1] gpio_pin_oe_o,
  input  wire logic       mic_bias_current_detect_i,
  input  wire logic       mic_short_detect_i,
  input  wire logic       thermal_cutout_i,
  input  wire logic       thermal_polarity_i,
  input  wire logic       aux_data_available_i,
  input  wire logic       auxiliary_converter_active_i,
  input  wire logic       low_battery_comparator_i,
  input  wire logic       dead_battery_comparator_i,
  input  wire logic       dead_battery_on_i,
  input  wire logic [3:0] pcm_pin_out_i,
  input  wire logic       spdif_out_i,
  output logic            mask_o,
  output logic            external_reset_input_o,
  output logic            cmp_b_reference_select_o,
  output logic      [1:0] cmp_b_source_select_o,
  output logic            cmp_b_power_down_o,
  output logic            irq_o
);
  // ========================================================================
  // state
  typedef struct packed {
    logic [15:0] pcm;
    logic [15:0] dir;
    logic [15:0] pol;
    logic [15:0] sticky;
    logic [15:0] wake;
    logic [15:0] status;
    logic [15:0] share;
    logic [15:0] alarm;
    logic [15:0] cmp;
    logic [15:0] lvl;
    logic [15:0] s1;
    logic [15:0] s2;
    logic [5:0]  div;
    logic        bclk;
    logic [5:0]  rcnt;
    logic [47:0] rx;
    logic [47:0] tx;
    logic        rd_pend;
    logic [15:0] rd_data;
    logic [8:1]  pin_o;
    logic [8:1]  pin_oe;
    logic        mask;
    logic        ext_rst;
    logic        irq;
  } cgi_dev_type;
  cgi_dev_type st_q;
  cgi_dev_type st_d;

  logic        smp;
  logic        frame_tick;
  logic        sync_s;
  logic        sdo_s;
  logic [47:0] rx_new;
  logic        cmd_ok;
  logic        cmd_rd;
  logic [6:0]  cmd_addr;
  logic [15:0] cmd_wd;
  logic        cmp_b_on;
  logic [15:0] raw;
  logic [15:0] pol_eff;
  logic [15:0] act_pre;
  logic [15:0] act;
  logic [15:0] valid;
  logic [15:0] keep;
  logic [8:1]  owned;
  logic [8:1]  pcm_pin;
  logic [8:1]  sec_drv;
  logic [8:1]  sec_lvl;
  logic        low_conf;

  // ========================================================================
  // register read mux
  function automatic logic [15:0] reg_read(input cgi_dev_type s, input logic [6:0] a);
    logic [15:0] r;
    r = 16'h0000;
    case (a)
      cgi_pkg::OFF_PCM_PIN_SELECT:     r = s.pcm;
      cgi_pkg::OFF_GPIO_DIRECTION:     r = s.dir;
      cgi_pkg::OFF_GPIO_POLARITY:      r = s.pol;
      cgi_pkg::OFF_GPIO_STICKY:        r = s.sticky;
      cgi_pkg::OFF_GPIO_WAKEUP:        r = s.wake;
      cgi_pkg::OFF_GPIO_STATUS:        r = s.status; // [RULE_19]
      cgi_pkg::OFF_PIN_FUNCTION_SHARE: r = s.share;
      cgi_pkg::OFF_ALARM_CONTROL:      r = s.alarm;
      cgi_pkg::OFF_COMPARATOR_CONFIG:  r = s.cmp;
      default:                         r = 16'h0000;
    endcase
    return r;
  endfunction : reg_read

  // ========================================================================
  // low battery confirmation timer
  cgi_alarm_debounce #(
    .DELAY_BASE (DELAY_BASE)
  ) u_debounce (
    .sys_clk_i    (sys_clk_i),
    .sys_rst_i    (sys_rst_i),
    .frame_tick_i (frame_tick),
    .delay_sel_i  (st_q.alarm[cgi_pkg::DELAY_LO +: 3]),
    .cond_i       (act_pre[cgi_pkg::BIT_LOW_BATT] & cmp_b_on),
    .confirmed_o  (low_conf)
  );

  always_comb begin
    st_d = st_q;
    // synchronisers: pins, virtual sources, link inputs
    st_d.s1 = {dead_battery_comparator_i, low_battery_comparator_i, link_if.sdo,
               aux_data_available_i, thermal_cutout_i, mic_short_detect_i,
               mic_bias_current_detect_i, gpio_pin_i, link_if.sync};
    st_d.s2 = st_q.s1;
    sync_s  = st_q.s2[0];
    sdo_s   = st_q.s2[13];

    // bit clock divider; sample just before the rising edge
    smp = (st_q.div == 6'(LINK_HALF - 1)) && !st_q.bclk;
    if (st_q.div == 6'(LINK_HALF - 1)) begin
      st_d.div  = 6'h00;
      st_d.bclk = ~st_q.bclk;
    end else begin
      st_d.div = st_q.div + 6'h01;
    end

    // ======================================================================
    // comparator control
    cmp_b_on = st_q.cmp[cgi_pkg::REF_SEL_BIT]
             | (st_q.cmp[cgi_pkg::SRC_SEL_LO +: 2] != 2'b00); // [RULE_02]

    // ======================================================================
    // input status
    raw = {st_q.s2[15], st_q.s2[14], 1'b0, st_q.s2[12:9], st_q.s2[8:1], 1'b0}; // [RULE_12]
    pol_eff = st_q.pol;
    pol_eff[cgi_pkg::BIT_THERMAL] = thermal_polarity_i;
    act_pre = raw ~^ pol_eff; // [RULE_16]
    pcm_pin = st_q.pcm[cgi_pkg::PCM_SEL_BIT] ? 8'b0001_1101 : 8'h00; // [RULE_10]
    owned   = ~pcm_pin & {st_q.share[8:2], 1'b1}; // [RULE_11]
    valid   = {dead_battery_on_i, cmp_b_on, 1'b0, auxiliary_converter_active_i,
               3'b111, owned, 1'b0}; // [RULE_13] [RULE_14]
    act     = act_pre;
    if (st_q.alarm[cgi_pkg::DELAY_LO +: 3] != 3'h0) begin
      act[cgi_pkg::BIT_LOW_BATT] = low_conf; // [RULE_03] [RULE_04]
    end
    act = act & valid;

    // ======================================================================
    // link receive and transmit
    frame_tick = 1'b0;
    rx_new     = {st_q.rx[46:0], sdo_s};
    cmd_ok     = 1'b0;
    if (smp) begin
      if (sync_s) begin
        frame_tick   = 1'b1;
        st_d.rx      = rx_new;
        st_d.rcnt    = 6'h01;
        st_d.tx      = {st_q.rd_pend, st_q.rd_data, st_q.status, 3'b000,
                        st_q.irq, 11'h000}; // [RULE_08] [RULE_09]
        st_d.rd_pend = 1'b0;
      end else begin
        st_d.tx = {st_q.tx[46:0], 1'b0};
        if (st_q.rcnt != 6'h00 && st_q.rcnt < 6'(cgi_pkg::PAYLOAD_BITS)) begin
          st_d.rx   = rx_new;
          st_d.rcnt = st_q.rcnt + 6'h01;
          cmd_ok    = (st_q.rcnt == 6'(cgi_pkg::PAYLOAD_BITS - 1));
        end
      end
    end
    cmd_rd   = rx_new[cgi_pkg::CMD_READ_POS];
    cmd_addr = rx_new[cgi_pkg::CMD_ADDR_LO +: 7];
    cmd_wd   = rx_new[cgi_pkg::CMD_WDATA_LO +: 16];
    keep     = 16'hffff;
    if (cmd_ok) begin
      st_d.lvl = rx_new[cgi_pkg::CMD_GPIO_LO +: 16]; // [RULE_07]
    end
    if (cmd_ok && rx_new[cgi_pkg::CMD_VALID_POS]) begin
      if (cmd_rd) begin
        st_d.rd_data = reg_read(st_q, cmd_addr);
        st_d.rd_pend = 1'b1;
      end else begin
        case (cmd_addr)
          cgi_pkg::OFF_PCM_PIN_SELECT:
            st_d.pcm = cmd_wd & cgi_pkg::WR_PCM;
          cgi_pkg::OFF_GPIO_DIRECTION:
            st_d.dir = cmd_wd | ~cgi_pkg::WR_DIRECTION; // [RULE_15]
          cgi_pkg::OFF_GPIO_POLARITY:
            st_d.pol = cmd_wd;
          cgi_pkg::OFF_GPIO_STICKY:
            st_d.sticky = cmd_wd;
          cgi_pkg::OFF_GPIO_WAKEUP:
            st_d.wake = cmd_wd;
          cgi_pkg::OFF_GPIO_STATUS:
            keep = cmd_wd;
          cgi_pkg::OFF_PIN_FUNCTION_SHARE:
            st_d.share = cmd_wd & cgi_pkg::WR_SHARE;
          cgi_pkg::OFF_ALARM_CONTROL:
            st_d.alarm = cmd_wd & cgi_pkg::WR_ALARM;
          cgi_pkg::OFF_COMPARATOR_CONFIG:
            st_d.cmp = cmd_wd & cgi_pkg::WR_COMPARATOR;
          default: ;
        endcase
      end
    end
    // latched bits keep until written 0; a new event wins over the clear
    st_d.status = (st_q.status & keep & st_q.sticky) | act; // [RULE_17] [RULE_19] [RULE_06]
    st_d.irq    = |(st_q.status & st_q.wake); // [RULE_18] [RULE_24]

    // ======================================================================
    // pin drivers and secondary functions
    sec_drv = {~st_q.share[8], 1'b0, ~st_q.share[6], ~st_q.share[5],
               ~st_q.share[4], 1'b0, ~st_q.share[2], 1'b0}; // [RULE_22]
    sec_drv = (sec_drv & ~pcm_pin) | pcm_pin;
    sec_lvl = {spdif_out_i, 1'b0, st_q.s2[12], spdif_out_i, st_q.s2[12], // [RULE_21] [RULE_22]
               pcm_pin_out_i[1] & pcm_pin[3], st_q.irq, pcm_pin_out_i[0] & pcm_pin[1]};
    sec_lvl[5] = pcm_pin[5] ? pcm_pin_out_i[3] : spdif_out_i;
    sec_lvl[4] = pcm_pin[4] ? pcm_pin_out_i[2] : st_q.s2[12];
    st_d.pin_o  = (owned & st_q.lvl[8:1]) | (~owned & sec_lvl); // [RULE_07]
    st_d.pin_oe = ~st_q.dir[8:1] & (owned | sec_drv); // [RULE_15] [RULE_09]
    st_d.mask = (~owned[4] & ~pcm_pin[4] & st_q.dir[4] & st_q.s2[4])
              | (~owned[6] & st_q.dir[6] & st_q.s2[6]); // [RULE_21]
    st_d.ext_rst = ~st_q.s2[7] & ~st_q.alarm[cgi_pkg::RST_DIS_BIT]; // [RULE_23]
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_q       <= '0;
      st_q.dir   <= cgi_pkg::RST_DIRECTION;
      st_q.pol   <= cgi_pkg::RST_POLARITY;
      st_q.share <= cgi_pkg::RST_SHARE;
    end else begin
      st_q <= st_d;
    end
  end

  // ========================================================================
  // outputs
  assign link_if.bit_clk          = st_q.bclk;
  assign link_if.sdi              = st_q.tx[47];
  assign gpio_pin_o               = st_q.pin_o;
  assign gpio_pin_oe_o            = st_q.pin_oe;
  assign mask_o                   = st_q.mask;
  assign external_reset_input_o   = st_q.ext_rst;
  assign cmp_b_reference_select_o = st_q.cmp[cgi_pkg::REF_SEL_BIT]; // [RULE_01]
  assign cmp_b_source_select_o    = st_q.cmp[cgi_pkg::SRC_SEL_LO +: 2]; // [RULE_02]
  assign cmp_b_power_down_o       = ~cmp_b_on;
  assign irq_o                    = st_q.irq; // [RULE_09]
endmodule : cgi_codec_gpio

// ---- cgi_pkg.sv ----
// Purpose: shared constants for the codec gpio block and its link controller
// Assumes: short serial frame carrying one register command and slot 12
// Notes:   device makes the link bit clock; controller follows it
// ==========================================================================
// Overview of operation
// [RULE_01] reference select: 0 half supply, 1 aux four
// [RULE_02] source field: 00 half/off, 01 aux1, 10 aux2
// [RULE_03] delayed low battery: no status, no interrupt
// [RULE_04] on expiry resample; set status only if active
// [RULE_05] delay code n selects 2^(12+n) frames
// [RULE_06] eight pin gpios, status and slot bits each
// [RULE_07] slot 12 out bits drive output pins
// [RULE_08] inputs reported in status and every slot 12
// [RULE_09] interrupt over link or level pin
// [RULE_10] pcm select takes pins 1,3,4,5 away
// [RULE_11] share bits 8:2 default gpio, 0 secondary
// [RULE_12] seven virtual inputs, never outputs; code has six, bit 13 reads 0
// [RULE_13] comparators at bits 14,15, valid when on
// [RULE_14] data available at bit 12 while converter active
// [RULE_15] direction: 0 output, 1 input; 9-15 inputs
// [RULE_16] polarity: 0 active low, 1 active high
// [RULE_17] sticky bit makes input latching
// [RULE_18] wakeup bit enables that bit's interrupt
// [RULE_19] status read current; write 0 clears latch
// [RULE_20] software scans status high to low, clears
// [RULE_21] released pins 4,6: data avail out or mask in
// [RULE_22] released pins 5,8 drive spdif when output
// [RULE_23] software disables reset function before gpio 7
// [RULE_24] interrupt is or of status and wakeup
package cgi_pkg;
  // ========================================================================
  // link framing
  localparam int FRAME_BITS    = 64;
  localparam int PAYLOAD_BITS  = 48;
  localparam int LINK_HALF_DEF = 4;
  localparam int CMD_VALID_POS = 47;
  localparam int CMD_READ_POS  = 46;
  localparam int CMD_ADDR_LO   = 39;
  localparam int CMD_WDATA_LO  = 23;
  localparam int CMD_GPIO_LO   = 7;
  localparam int RPY_VALID_POS = 47;
  localparam int RPY_RDATA_LO  = 31;
  localparam int RPY_GPIO_LO   = 15;
  localparam int RPY_IRQ_POS   = 11;
  // ========================================================================
  // device register map
  localparam logic [6:0] OFF_PCM_PIN_SELECT     = 7'h36;
  localparam logic [6:0] OFF_GPIO_DIRECTION     = 7'h4c;
  localparam logic [6:0] OFF_GPIO_POLARITY      = 7'h4e;
  localparam logic [6:0] OFF_GPIO_STICKY        = 7'h50;
  localparam logic [6:0] OFF_GPIO_WAKEUP        = 7'h52;
  localparam logic [6:0] OFF_GPIO_STATUS        = 7'h54;
  localparam logic [6:0] OFF_PIN_FUNCTION_SHARE = 7'h56;
  localparam logic [6:0] OFF_ALARM_CONTROL      = 7'h5a;
  localparam logic [6:0] OFF_COMPARATOR_CONFIG  = 7'h5c;
  localparam logic [15:0] RST_DIRECTION = 16'hffff;
  localparam logic [15:0] RST_POLARITY  = 16'hffff;
  localparam logic [15:0] RST_SHARE     = 16'h01fc;
  localparam logic [15:0] WR_DIRECTION  = 16'h01fe;
  localparam logic [15:0] WR_PCM        = 16'h8000;
  localparam logic [15:0] WR_SHARE      = 16'h01fc;
  localparam logic [15:0] WR_ALARM      = 16'he100;
  localparam logic [15:0] WR_COMPARATOR = 16'h0e00;
  localparam int PCM_SEL_BIT   = 15;
  localparam int DELAY_LO      = 13;
  localparam int RST_DIS_BIT   = 8;
  localparam int REF_SEL_BIT   = 11;
  localparam int SRC_SEL_LO    = 9;
  localparam int BIT_THERMAL   = 11;
  localparam int BIT_AUX_DATA  = 12;
  localparam int BIT_LOW_BATT  = 14;
  localparam int DELAY_BASE_DEF = 13;
  // ========================================================================
  // controller apb map
  localparam logic [7:0] APB_CMD      = 8'h00;
  localparam logic [7:0] APB_STATUS   = 8'h04;
  localparam logic [7:0] APB_GPIO_OUT = 8'h08;
  localparam logic [7:0] APB_GPIO_IN  = 8'h0c;
  localparam int CMD_READ_BIT = 24;
  localparam int CMD_ADDR_BIT = 16;
endpackage : cgi_pkg

// ---- cgi_link_if.sv ----
// Purpose: serial link between codec gpio block and controller
// Assumes: bit_clk made by the device end
// Notes:   all signals single-driver, no tristate
interface cgi_link_if;
  logic bit_clk;
  logic sync;
  logic sdo;
  logic sdi;
  modport dev (output bit_clk, output sdi, input sync, input sdo);
  modport ctl (input bit_clk, input sdi, output sync, output sdo);
endinterface : cgi_link_if

// ---- cgi_alarm_debounce.sv ----
// Purpose: low battery alarm confirmation timer counted in link frames
// Assumes: frame_tick_i one pulse per frame, cond_i already synchronised
// Notes:   only used while delay_sel_i is nonzero
module cgi_alarm_debounce #(
  parameter int DELAY_BASE = cgi_pkg::DELAY_BASE_DEF
) (
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       frame_tick_i,
  input  wire logic [2:0] delay_sel_i,
  input  wire logic       cond_i,
  output logic            confirmed_o
);
  localparam int CW = DELAY_BASE + 7;
  typedef enum logic [1:0] {DB_IDLE = 2'b01, DB_RUN = 2'b10} cgi_db_state_type;
  typedef struct packed {
    cgi_db_state_type state;
    logic [CW-1:0]    cnt;
    logic             conf;
  } cgi_db_type;
  cgi_db_type st_q;
  cgi_db_type st_d;
  logic [CW-1:0] limit;

  always_comb begin
    st_d  = st_q;
    limit = CW'(1) << (DELAY_BASE - 1 + int'(delay_sel_i));
    case (st_q.state)
      DB_IDLE: begin
        if (!cond_i) begin
          st_d.conf = 1'b0;
        end else if (!st_q.conf && delay_sel_i != 3'h0) begin
          st_d.state = DB_RUN; // [RULE_03]
          st_d.cnt   = '0;
        end
      end
      DB_RUN: begin
        if (delay_sel_i == 3'h0) begin
          st_d.state = DB_IDLE;
        end else if (frame_tick_i) begin
          st_d.cnt = st_q.cnt + CW'(1);
          if (st_q.cnt + CW'(1) == limit) begin // [RULE_05]
            st_d.state = DB_IDLE;
            st_d.conf  = cond_i; // [RULE_04]
          end
        end
      end
      default: st_d.state = DB_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_q <= '{state: DB_IDLE, cnt: '0, conf: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign confirmed_o = st_q.conf;
endmodule : cgi_alarm_debounce

// ---- cgi_link_controller.sv ----
// Purpose: link controller end; software drives it over apb
// Assumes: bit_clk comes from the device and is sampled by sys_clk_i
// Notes:   one register command in flight at a time
module cgi_link_controller (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  cgi_link_if.ctl          link_if,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o
);
  typedef enum logic [2:0] {
    C_IDLE = 3'b001,
    C_PEND = 3'b010,
    C_WAIT = 3'b100
  } cgi_ctl_state_type;
  typedef struct packed {
    cgi_ctl_state_type state;
    logic [2:0]  bs;
    logic [1:0]  ds;
    logic [5:0]  cnt;
    logic [47:0] osr;
    logic        sync;
    logic [47:0] irx;
    logic        cmd_rd;
    logic [6:0]  cmd_addr;
    logic [15:0] cmd_wd;
    logic [15:0] gpio_out;
    logic [15:0] gpio_in;
    logic        irq;
    logic [15:0] rdata;
    logic [31:0] prdata;
  } cgi_ctl_type;
  cgi_ctl_type st_q;
  cgi_ctl_type st_d;
  logic        rise;
  logic        fall;
  logic        wr;
  logic        mapped;
  logic [47:0] rx_new;

  always_comb begin
    st_d    = st_q;
    st_d.bs = {st_q.bs[1:0], link_if.bit_clk};
    st_d.ds = {st_q.ds[0], link_if.sdi};
    rise    = st_q.bs[1] & ~st_q.bs[2];
    fall    = ~st_q.bs[1] & st_q.bs[2];
    rx_new  = {st_q.irx[46:0], st_q.ds[1]};

    // ======================================================================
    // apb slave, zero wait states
    mapped = (paddr_i == cgi_pkg::APB_CMD) || (paddr_i == cgi_pkg::APB_STATUS)
          || (paddr_i == cgi_pkg::APB_GPIO_OUT) || (paddr_i == cgi_pkg::APB_GPIO_IN);
    if (psel_i && !penable_i) begin
      case (paddr_i)
        cgi_pkg::APB_CMD:      st_d.prdata = {7'h00, st_q.cmd_rd, 1'b0, st_q.cmd_addr,
                                              st_q.cmd_wd};
        cgi_pkg::APB_STATUS:   st_d.prdata = {st_q.rdata, 14'h0000, st_q.irq,
                                              st_q.state != C_IDLE}; // [RULE_20]
        cgi_pkg::APB_GPIO_OUT: st_d.prdata = {16'h0000, st_q.gpio_out};
        cgi_pkg::APB_GPIO_IN:  st_d.prdata = {16'h0000, st_q.gpio_in}; // [RULE_20]
        default:               st_d.prdata = 32'h0000_0000;
      endcase
    end
    wr = psel_i & penable_i & pwrite_i;
    if (wr && paddr_i == cgi_pkg::APB_CMD && st_q.state == C_IDLE) begin
      st_d.cmd_rd   = pwdata_i[cgi_pkg::CMD_READ_BIT];
      st_d.cmd_addr = pwdata_i[cgi_pkg::CMD_ADDR_BIT +: 7];
      st_d.cmd_wd   = pwdata_i[15:0];
      st_d.state    = C_PEND;
    end
    if (wr && paddr_i == cgi_pkg::APB_GPIO_OUT) begin
      st_d.gpio_out = pwdata_i[15:0];
    end

    // ======================================================================
    // frame out on rising bit clock
    if (rise) begin
      st_d.cnt  = (st_q.cnt == 6'(cgi_pkg::FRAME_BITS - 1)) ? 6'h00 : st_q.cnt + 6'h01;
      st_d.sync = (st_d.cnt == 6'h00);
      if (st_d.sync) begin
        st_d.osr = {st_q.state == C_PEND, st_q.cmd_rd, st_q.cmd_addr, st_q.cmd_wd,
                    st_q.gpio_out, 4'h0, 3'b000}; // [RULE_07]
        if (st_q.state == C_PEND) begin
          st_d.state = st_q.cmd_rd ? C_WAIT : C_IDLE;
        end
      end else begin
        st_d.osr = {st_q.osr[46:0], 1'b0};
      end
    end

    // ======================================================================
    // reply in on falling bit clock
    if (fall && st_q.cnt != 6'h00 && st_q.cnt <= 6'(cgi_pkg::PAYLOAD_BITS)) begin
      st_d.irx = rx_new;
      if (st_q.cnt == 6'(cgi_pkg::PAYLOAD_BITS)) begin
        st_d.gpio_in = rx_new[cgi_pkg::RPY_GPIO_LO +: 16]; // [RULE_08]
        st_d.irq     = rx_new[cgi_pkg::RPY_IRQ_POS]; // [RULE_09]
        if (rx_new[cgi_pkg::RPY_VALID_POS] && st_q.state == C_WAIT) begin
          st_d.rdata = rx_new[cgi_pkg::RPY_RDATA_LO +: 16];
          st_d.state = C_IDLE;
        end
      end
    end

    case (st_q.state)
      C_IDLE, C_PEND, C_WAIT: ;
      default: st_d.state = C_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_q       <= '0;
      st_q.state <= C_IDLE;
      st_q.cnt   <= 6'(cgi_pkg::FRAME_BITS - 1);
    end else begin
      st_q <= st_d;
    end
  end

  assign link_if.sync = st_q.sync;
  assign link_if.sdo  = st_q.osr[47];
  assign prdata_o     = st_q.prdata;
  assign pready_o     = 1'b1;
  assign pslverr_o    = psel_i & penable_i & ~mapped;
  assign irq_o        = st_q.irq;
endmodule : cgi_link_controller

// ---- cgi_link_checker.sv ----
// Purpose: link wire timing and framing checks
// Assumes: LINK_HALF 4, frames of 64 bit periods
// Notes:   sees only the interface signals
module cgi_link_checker (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic bit_clk,
  input wire logic sync,
  input wire logic sdo,
  input wire logic sdi
);
  // ==========================================================================
  // frame position since last sync rise
  logic       sync_q;
  logic       seen_q;
  logic [9:0] pos_q;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sync_q <= 1'b0;
      seen_q <= 1'b0;
      pos_q  <= 10'h000;
    end else begin
      sync_q <= sync;
      seen_q <= seen_q | (sync & ~sync_q);
      pos_q  <= (sync & ~sync_q) ? 10'h001 : pos_q + 10'h001;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence high_phase; bit_clk [*4]; endsequence
  sequence low_phase; !bit_clk [*4]; endsequence
  // ==========================================================================
  // assertions
  AST_CLK_HIGH: assert property ($rose(bit_clk) |-> high_phase ##1 !bit_clk)
    else $error("link clock high phase wrong");
  AST_CLK_LOW: assert property ($fell(bit_clk) |-> low_phase ##1 bit_clk)
    else $error("link clock low phase wrong");
  AST_SYNC_WIDTH: assert property ($rose(sync) |-> sync [*8] ##1 !sync)
    else $error("sync width wrong");
  AST_FRAME_LEN: assert property (seen_q && $rose(sync) |-> pos_q == 10'd512)
    else $error("frame length wrong");
  AST_SDO_HOLD: assert property (!bit_clk && !$past(bit_clk) |-> $stable(sdo))
    else $error("sdo moved in low phase");
  AST_SYNC_HOLD: assert property (!bit_clk && !$past(bit_clk) |-> $stable(sync))
    else $error("sync moved in low phase");
  AST_SDO_TAIL: assert property (seen_q && pos_q inside {[400:500]} |-> !sdo)
    else $error("sdo busy after payload");
  AST_SDI_ZERO: assert property (seen_q && pos_q inside {[330:380]} |-> !sdi)
    else $error("reply spare bits not zero");
endmodule : cgi_link_checker

// ---- tb_top.sv ----
// Purpose: self-checking bench, device and controller joined by the link
// Assumes: DELAY_BASE 2, so delay code 1 waits 4 frames
// Notes:   mreg models the expected device register reads
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, psel, pen, pwr, pready, perr, err, dirq, cirq, ref_s, pd;
  logic [1:0]  src;
  logic [7:0]  paddr, pin, pout, poe;
  logic [31:0] pwd, prd, rd;
  logic [15:0] pv;
  logic [9:0]  virt;
  logic [15:0] mreg [int];
  int          bad_count, num_checks;
  cgi_link_if link_i ();
  cgi_codec_gpio #(.DELAY_BASE(2)) cgi_codec_gpio_i (.sys_clk_i(clk), .sys_rst_i(rst),
    .link_if(link_i), .gpio_pin_i(pin), .gpio_pin_o(pout), .gpio_pin_oe_o(poe),
    .mic_bias_current_detect_i(virt[0]), .mic_short_detect_i(virt[1]),
    .thermal_cutout_i(virt[2]), .thermal_polarity_i(virt[3]), .aux_data_available_i(virt[4]),
    .auxiliary_converter_active_i(virt[5]), .low_battery_comparator_i(virt[6]),
    .dead_battery_comparator_i(virt[7]), .dead_battery_on_i(virt[8]), .pcm_pin_out_i(4'h0),
    .spdif_out_i(virt[9]), .mask_o(), .external_reset_input_o(), .cmp_b_reference_select_o(ref_s),
    .cmp_b_source_select_o(src), .cmp_b_power_down_o(pd), .irq_o(dirq));
  cgi_link_controller cgi_link_controller_i (.sys_clk_i(clk), .sys_rst_i(rst), .link_if(link_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(pready), .pslverr_o(perr), .irq_o(cirq));
  cgi_link_checker cgi_link_checker_i (.sys_clk_i(clk), .sys_rst_i(rst),
    .bit_clk(link_i.bit_clk), .sync(link_i.sync), .sdo(link_i.sdo), .sdi(link_i.sdi));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================================
  // tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel  <= 1'b1;
    pwr   <= w;
    paddr <= a;
    pwd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      bad_count++;
      tally_and_finish();
    end
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task automatic dcmd(input logic r, input logic [6:0] a, input logic [15:0] d);
    int n;
    apb(1'b1, cgi_pkg::APB_CMD, {7'h00, r, 1'b0, a, d});
    n = 0;
    do begin
      apb(1'b0, cgi_pkg::APB_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 1000);
    if (n >= 1000) begin
      bad_count++;
      tally_and_finish();
    end
    if (!r) repeat (512) @(posedge clk);
    if (!r && mreg.exists(a)) mreg[a] = (a == cgi_pkg::OFF_GPIO_DIRECTION) ?
      (d | ~cgi_pkg::WR_DIRECTION) : (d & ((a == cgi_pkg::OFF_PIN_FUNCTION_SHARE) ?
      cgi_pkg::WR_SHARE : cgi_pkg::WR_COMPARATOR));
  endtask : dcmd
  task automatic rd_all();
    foreach (mreg[a]) begin
      dcmd(1'b1, 7'(a), 16'h0000);
      `CHK("reg", mreg[a], rd[31:16])
    end
  endtask : rd_all
  // ==========================================================================
  // main sequence
  initial begin
    {rst, psel, pen, pwr, paddr, pwd, pin, virt} = {1'b1, 61'h0};
    {bad_count, num_checks} = {32'd0, 32'd0};
    mreg[cgi_pkg::OFF_GPIO_DIRECTION] = cgi_pkg::RST_DIRECTION;
    mreg[cgi_pkg::OFF_GPIO_POLARITY] = cgi_pkg::RST_POLARITY;
    mreg[cgi_pkg::OFF_PIN_FUNCTION_SHARE] = cgi_pkg::RST_SHARE;
    mreg[cgi_pkg::OFF_COMPARATOR_CONFIG] = 16'h0000;
    void'($urandom(32'h8458eb37));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_all();
    dcmd(1'b0, cgi_pkg::OFF_ALARM_CONTROL, 16'h0100);
    dcmd(1'b0, cgi_pkg::OFF_COMPARATOR_CONFIG, 16'h0a00);
    `CHK("ref", 1'b1, ref_s)
    `CHK("src", 2'b01, src)
    dcmd(1'b0, cgi_pkg::OFF_COMPARATOR_CONFIG, 16'h0000);
    `CHK("pd", 1'b1, pd)
    pv = 16'($urandom);
    dcmd(1'b0, cgi_pkg::OFF_GPIO_DIRECTION, 16'h0000);
    apb(1'b1, cgi_pkg::APB_GPIO_OUT, {16'h0000, pv});
    repeat (1100) @(posedge clk);
    `CHK("oe", 8'hff, poe)
    `CHK("out", pv[8:1], pout)
    dcmd(1'b0, cgi_pkg::OFF_GPIO_DIRECTION, 16'hffff);
    pin <= 8'($urandom);
    repeat (1100) @(posedge clk);
    apb(1'b0, cgi_pkg::APB_GPIO_IN, 32'h0);
    `CHK("in", pin, rd[8:1])
    dcmd(1'b1, cgi_pkg::OFF_GPIO_STATUS, 16'h0000);
    `CHK("stat", pin, rd[24:17])
    pin <= 8'h00;
    dcmd(1'b0, cgi_pkg::OFF_GPIO_STICKY, 16'h0002);
    dcmd(1'b0, cgi_pkg::OFF_GPIO_WAKEUP, 16'h4002);
    pin <= 8'h01;
    repeat (20) @(posedge clk);
    pin <= 8'h00;
    repeat (1100) @(posedge clk);
    `CHK("irq", 1'b1, dirq)
    `CHK("cirq", 1'b1, cirq)
    dcmd(1'b0, cgi_pkg::OFF_GPIO_STATUS, 16'h0000);
    `CHK("irq", 1'b0, dirq)
    dcmd(1'b0, cgi_pkg::OFF_COMPARATOR_CONFIG, 16'h0200);
    `CHK("ref", 1'b0, ref_s)
    dcmd(1'b0, cgi_pkg::OFF_ALARM_CONTROL, 16'h2100);
    virt[6] <= 1'b1;
    repeat (512) @(posedge clk);
    `CHK("irq", 1'b0, dirq)
    virt[6] <= 1'b0;
    repeat (3000) @(posedge clk);
    `CHK("irq", 1'b0, dirq)
    virt[6] <= 1'b1;
    repeat (1024) @(posedge clk);
    `CHK("irq", 1'b0, dirq)
    repeat (2000) @(posedge clk);
    `CHK("irq", 1'b1, dirq)
    dcmd(1'b1, cgi_pkg::OFF_GPIO_STATUS, 16'h0000);
    `CHK("lowbat", 1'b1, rd[30])
    virt[6] <= 1'b0;
    apb(1'b0, 8'h10, 32'h0);
    `CHK("err", 1'b1, err)
    rd_all();
    tally_and_finish();
  end
endmodule : tb_top
